// >>> pkg/adc_cfg_pkg.sv
// constants, codes and carriers for the two converter setup registers
// assumes one core clock; commands arrive already decoded from the serial layer
package adc_cfg_pkg;

    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned COUNT_W_DEFAULT = 8;

    // register addresses as used by the register read and write commands
    localparam logic [1:0] CONV_SETUP_ADDR  = 2'h1;
    localparam logic [1:0] INTEG_SETUP_ADDR = 2'h2;
    localparam logic [7:0] CONV_SETUP_RESET = 8'h00;
    localparam logic [7:0] INTEG_SETUP_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // conversion_setup field positions
    localparam int unsigned DR_MSB     = 7;
    localparam int unsigned DR_LSB     = 5;
    localparam int unsigned SPEED_BIT  = 4;
    localparam int unsigned CONV_BIT   = 3;
    localparam int unsigned REF_MSB    = 2;
    localparam int unsigned REF_LSB    = 1;
    localparam int unsigned TEMP_BIT   = 0;

    // integrity_and_excitation_setup field positions
    localparam int unsigned READY_BIT   = 7;
    localparam int unsigned COUNT_BIT   = 6;
    localparam int unsigned INTEG_MSB   = 5;
    localparam int unsigned INTEG_LSB   = 4;
    localparam int unsigned BURNOUT_BIT = 3;
    localparam int unsigned EXC_MSB     = 2;
    localparam int unsigned EXC_LSB     = 0;

    localparam logic [2:0] DR_RESERVED = 3'h7;

    // modulator clock in kHz
    localparam logic [9:0] MOD_CLK_NORMAL_KHZ = 10'h100;
    localparam logic [9:0] MOD_CLK_TURBO_KHZ  = 10'h200;

    // normal mode sample rates in samples per second; turbo doubles them
    localparam logic [10:0] NORMAL_SPS [8] = '{
        11'd20, 11'd45, 11'd90, 11'd175, 11'd330, 11'd600, 11'd1000, 11'd0
    };

    // excitation current per source in microamps
    localparam logic [10:0] EXC_UA [8] = '{
        11'd0, 11'd10, 11'd50, 11'd100, 11'd250, 11'd500, 11'd1000, 11'd1500
    };

    typedef enum logic [1:0] {
        REF_INTERNAL   = 2'h0,
        REF_EXTERNAL   = 2'h1,
        REF_SUPPLY     = 2'h2,
        REF_SUPPLY_ALT = 2'h3
    } ref_sel_e;

    typedef enum logic [1:0] {
        INTEG_NONE     = 2'h0,
        INTEG_INVERT   = 2'h1,
        INTEG_CRC16    = 2'h2,
        INTEG_RESERVED = 2'h3
    } integrity_e;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [1:0] addr;
        logic [7:0] wdata;
    } cmd_s;

    typedef struct packed {
        logic [10:0] rate_sps;
        logic [9:0]  mod_clk_khz;
        logic        continuous;
        ref_sel_e    ref_sel;
        logic        temp_mode;
        logic        cfg0_bypass;
        logic        counter_en;
        integrity_e  integrity;
        logic        burnout_en;
        logic [10:0] exc_ua;
        logic        reserved_code;
    } setup_s;

endpackage

// >>> logic/setting_decode.sv
// turns the two raw setup bytes into the settings the analog path uses
// assumes bytes come straight from registers; output is combinational
`timescale 1ns/1ps

module setting_decode (
    input  wire logic [7:0]           conv_i,
    input  wire logic [7:0]           integ_i,
    output adc_cfg_pkg::setup_s       setup_o
);
    import adc_cfg_pkg::*;

    logic [2:0] rate_code;
    logic [1:0] ref_code;
    logic       turbo;
    logic       temp;

    assign rate_code = conv_i[DR_MSB:DR_LSB];
    assign ref_code  = conv_i[REF_MSB:REF_LSB];
    assign turbo     = conv_i[SPEED_BIT];
    assign temp      = conv_i[TEMP_BIT];

    // table lookups; reserved rate code reads as zero rate
    always_comb begin
        setup_o = '0;
        setup_o.rate_sps = turbo ? {NORMAL_SPS[rate_code][9:0], 1'b0}
                                 : NORMAL_SPS[rate_code]; // R4
        setup_o.mod_clk_khz = turbo ? MOD_CLK_TURBO_KHZ
                                    : MOD_CLK_NORMAL_KHZ; // R5 R6
        setup_o.continuous = conv_i[CONV_BIT]; // R7
        // temperature mode forces the internal reference
        if (temp || ref_code == REF_INTERNAL) begin
            setup_o.ref_sel = REF_INTERNAL; // R8 R12
        end else if (ref_code == REF_EXTERNAL) begin
            setup_o.ref_sel = REF_EXTERNAL; // R9
        end else begin
            setup_o.ref_sel = REF_SUPPLY; // R10
        end
        setup_o.temp_mode   = temp; // R11
        setup_o.cfg0_bypass = temp; // R12
        setup_o.counter_en  = integ_i[COUNT_BIT]; // R15
        setup_o.integrity   = integrity_e'(integ_i[INTEG_MSB:INTEG_LSB]); // R16
        setup_o.burnout_en  = integ_i[BURNOUT_BIT]; // R17
        setup_o.exc_ua      = EXC_UA[integ_i[EXC_MSB:EXC_LSB]]; // R18
        setup_o.reserved_code = (rate_code == DR_RESERVED)
            || (integ_i[INTEG_MSB:INTEG_LSB] == INTEG_RESERVED);
    end

endmodule // setting_decode

// >>> logic/adc_setup_regs.sv
// setup registers one and two of the converter, with the result ready flag
// assumes commands, result events and read-outs come from logic on core_clk_i
`timescale 1ns/1ps

// Contract
// R1: conversion_setup at address one, resets zero
// R2: second register at address two, resets zero
// R3: bits seven to five hold data_rate_sel
// R4: rate codes give table rates, turbo doubled
// R5: speed bit zero gives 256 kHz normal
// R6: speed bit one gives 512 kHz turbo
// R7: bit three picks single-shot or continuous
// R8: reference code 00 selects internal reference
// R9: reference code 01 selects external inputs
// R10: codes 10 and 11 select analog supply
// R11: bit zero enables temperature sensor mode
// R12: temperature mode ignores register zero, internal reference
// R13: result_ready_flag read-only, high when result new
// R14: reading conversion data clears result_ready_flag
// R15: bit six enables the conversion data counter
// R16: bits five, four select integrity check
// R17: bit three turns on burn-out sources
// R18: bits two to zero set excitation current
// R19: access only by commands; power-down keeps values
// R20: controller avoids writing reserved codes
// R21: writes skip ready bit, update other fields
module adc_setup_regs #(
    parameter int unsigned COUNT_W = adc_cfg_pkg::COUNT_W_DEFAULT
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    input  adc_cfg_pkg::cmd_s         cmd_i,
    input  wire logic                 power_down_i,
    input  wire logic                 result_done_i,
    input  wire logic                 data_read_i,
    output logic [7:0]                rd_data_o,
    output logic                      rd_valid_o,
    output adc_cfg_pkg::setup_s       setup_o,
    output logic [COUNT_W-1:0]        sample_count_o,
    output logic                      power_down_o
);
    import adc_cfg_pkg::*;

    // refuse a counter with no bits
    if (COUNT_W < 1) begin : g_bad_width
        $error("COUNT_W must be at least one");
    end

    logic [7:0]         conv_q;
    logic [7:0]         conv_d;
    logic [6:0]         integ_q;
    logic [6:0]         integ_d;
    logic               ready_q;
    logic               ready_d;
    logic [7:0]         rd_data_q;
    logic [7:0]         rd_data_d;
    logic               rd_valid_q;
    logic               rd_valid_d;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    setup_s             setup_q;
    setup_s             setup_dec;
    logic               pd_q;
    logic               wr_conv;
    logic               wr_integ;
    logic               rd_req;
    logic               settled_q;

    // command decode; only register read and write commands reach here
    assign wr_conv  = cmd_i.valid && cmd_i.write
                      && (cmd_i.addr == CONV_SETUP_ADDR); // R19
    assign wr_integ = cmd_i.valid && cmd_i.write
                      && (cmd_i.addr == INTEG_SETUP_ADDR); // R19
    assign rd_req   = cmd_i.valid && !cmd_i.write;

    // setup register next values; power-down never touches them
    always_comb begin
        conv_d  = conv_q;
        integ_d = integ_q;
        if (wr_conv) begin
            conv_d = cmd_i.wdata; // R1 R3 R19
        end
        if (wr_integ) begin
            integ_d = cmd_i.wdata[6:0]; // R2 R21
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_q  <= CONV_SETUP_RESET; // R1
            integ_q <= INTEG_SETUP_RESET[6:0]; // R2
        end else begin
            conv_q  <= conv_d;
            integ_q <= integ_d;
        end
    end

    // ready flag: a new result in the clearing cycle still sets it
    always_comb begin
        ready_d = ready_q;
        if (result_done_i) begin
            ready_d = 1'b1; // R13
        end else if (data_read_i) begin
            ready_d = 1'b0; // R14
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ready_q <= INTEG_SETUP_RESET[READY_BIT];
        end else begin
            ready_q <= ready_d;
        end
    end

    // read answer one cycle after the command; unmapped reads give zero
    always_comb begin
        rd_valid_d = rd_req; // R19
        rd_data_d  = rd_data_q;
        if (rd_req) begin
            if (cmd_i.addr == CONV_SETUP_ADDR) begin
                rd_data_d = conv_q; // R1
            end else if (cmd_i.addr == INTEG_SETUP_ADDR) begin
                rd_data_d = {ready_q, integ_q}; // R2 R13
            end else begin
                rd_data_d = UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // data counter: cleared while disabled so it restarts cleanly
    always_comb begin
        count_d = count_q;
        if (!integ_q[COUNT_BIT]) begin
            count_d = '0; // R15
        end else if (result_done_i) begin
            count_d = count_q + 1'b1; // R15
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // decoded settings, registered so the analog side sees clean levels
    setting_decode u_decode (
        .conv_i  (conv_q),
        .integ_i ({ready_q, integ_q}),
        .setup_o (setup_dec)
    );

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            setup_q <= '0;
            pd_q    <= 1'b0;
        end else begin
            setup_q <= setup_dec; // R4 R5 R6 R7 R8 R9 R10 R11 R12
            pd_q    <= power_down_i; // R19
        end
    end

    assign rd_data_o      = rd_data_q;
    assign rd_valid_o     = rd_valid_q;
    assign setup_o        = setup_q;
    assign sample_count_o = count_q;
    assign power_down_o   = pd_q;

    // first edge out of reset still shows the cleared setup image; hold checks off
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            settled_q <= 1'b0;
        end else begin
            settled_q <= 1'b1;
        end
    end

    // checks on the register bank behaviour
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    a_conv_write_lands: assert property ( // R3
        wr_conv |=> conv_q == $past(cmd_i.wdata)
    ) else $error("conversion_setup write lost");

    a_integ_write_skips: assert property ( // R21
        wr_integ && !result_done_i && !data_read_i
        |=> integ_q == $past(cmd_i.wdata[6:0]) && ready_q == $past(ready_q)
    ) else $error("second register write wrong");

    a_ready_sets: assert property ( // R13
        result_done_i |=> ready_q
    ) else $error("ready flag not set by result");

    a_ready_clears: assert property ( // R14
        data_read_i && !result_done_i |=> !ready_q
    ) else $error("ready flag not cleared by read-out");

    a_read_conv_value: assert property ( // R1
        rd_req && cmd_i.addr == CONV_SETUP_ADDR
        |=> rd_valid_o && rd_data_o == $past(conv_q)
    ) else $error("conversion_setup read wrong");

    a_read_integ_value: assert property ( // R2
        rd_req && cmd_i.addr == INTEG_SETUP_ADDR
        |=> rd_valid_o && rd_data_o == {$past(ready_q), $past(integ_q)}
    ) else $error("second register read wrong");

    a_read_unmapped_zero: assert property ( // R19
        rd_req && cmd_i.addr != CONV_SETUP_ADDR && cmd_i.addr != INTEG_SETUP_ADDR
        |=> rd_valid_o && rd_data_o == 8'h00
    ) else $error("unmapped read not zero");

    a_read_pulse_once: assert property ( // R19
        !rd_req |=> !rd_valid_o
    ) else $error("read answer without request");

    a_top_rate_turbo: assert property ( // R4
        settled_q && conv_q[7:5] == 3'b110 && conv_q[4] |=> setup_o.rate_sps == 11'd2000
    ) else $error("turbo top rate wrong");

    a_base_rate_normal: assert property ( // R4
        settled_q && conv_q[7:5] == 3'b000 && !conv_q[4] |=> setup_o.rate_sps == 11'd20
    ) else $error("normal base rate wrong");

    a_mod_clock_turbo: assert property ( // R6
        settled_q && conv_q[4] |=> setup_o.mod_clk_khz == 10'd512
    ) else $error("turbo modulator clock wrong");

    a_mod_clock_normal: assert property ( // R5
        settled_q && !conv_q[4] |=> setup_o.mod_clk_khz == 10'd256
    ) else $error("normal modulator clock wrong");

    a_temp_forces_ref: assert property ( // R12
        settled_q && conv_q[0] |=> setup_o.ref_sel == REF_INTERNAL && setup_o.cfg0_bypass
    ) else $error("temperature mode reference wrong");

    a_supply_ref_both: assert property ( // R10
        settled_q && conv_q[2] && !conv_q[0] |=> setup_o.ref_sel == REF_SUPPLY
    ) else $error("supply reference not chosen");

    a_exc_top_current: assert property ( // R18
        settled_q && integ_q[2:0] == 3'b111 |=> setup_o.exc_ua == 11'd1500
    ) else $error("excitation current wrong");

    a_count_held_off: assert property ( // R15
        !integ_q[COUNT_BIT] |=> sample_count_o == '0
    ) else $error("counter runs while disabled");

    a_power_down_keeps: assert property ( // R19
        power_down_i && !wr_conv |=> conv_q == $past(conv_q)
    ) else $error("setup lost in power-down");

    a_reset_conv_zero: assert property ( // R1
        !settled_q |-> conv_q == CONV_SETUP_RESET
    ) else $error("conversion_setup reset value wrong");

    a_reset_integ_zero: assert property ( // R2
        !settled_q |-> {ready_q, integ_q} == INTEG_SETUP_RESET
    ) else $error("second register reset value wrong");

    a_data_rate_field: assert property ( // R3
        wr_conv |=> conv_q[7:5] == $past(cmd_i.wdata[7:5])
    ) else $error("data_rate_sel write lost");

    a_rate_mid_turbo: assert property ( // R4
        settled_q && conv_q[7:5] == 3'b011 && conv_q[4] |=> setup_o.rate_sps == 11'h15e
    ) else $error("turbo mid rate wrong");

    a_rate_mid_normal: assert property ( // R4
        settled_q && conv_q[7:5] == 3'b100 && !conv_q[4] |=> setup_o.rate_sps == 11'h14a
    ) else $error("normal mid rate wrong");

    a_conv_mode_follows: assert property ( // R7
        settled_q |=> setup_o.continuous == $past(conv_q[3])
    ) else $error("conversion mode wrong");

    a_internal_ref_code: assert property ( // R8
        settled_q && conv_q[2:1] == 2'b00 |=> setup_o.ref_sel == REF_INTERNAL
    ) else $error("internal reference not chosen");

    a_external_ref_code: assert property ( // R9
        settled_q && conv_q[2:1] == 2'b01 && !conv_q[0] |=> setup_o.ref_sel == REF_EXTERNAL
    ) else $error("external reference not chosen");

    a_temp_mode_flag: assert property ( // R11
        settled_q |=> setup_o.temp_mode == $past(conv_q[0])
    ) else $error("temperature mode flag wrong");

    a_ready_holds: assert property ( // R13
        !result_done_i && !data_read_i |=> ready_q == $past(ready_q)
    ) else $error("ready flag moved without event");

    a_counter_enable_out: assert property ( // R15
        settled_q |=> setup_o.counter_en == $past(integ_q[6])
    ) else $error("counter enable not passed on");

    a_count_steps_up: assert property ( // R15
        integ_q[6] && result_done_i |=> sample_count_o == $past(sample_count_o) + 1'b1
    ) else $error("counter missed a result");

    a_integrity_code: assert property ( // R16
        settled_q |=> setup_o.integrity == $past(integ_q[5:4])
    ) else $error("integrity selection wrong");

    a_burnout_follows: assert property ( // R17
        settled_q |=> setup_o.burnout_en == $past(integ_q[3])
    ) else $error("burn-out enable wrong");

    a_exc_off_code: assert property ( // R18
        settled_q && integ_q[2:0] == 3'b000 |=> setup_o.exc_ua == 11'h000
    ) else $error("excitation not off");

    a_integ_kept_pd: assert property ( // R19
        power_down_i && !wr_integ |=> integ_q == $past(integ_q)
    ) else $error("second register lost in power-down");

    c_ready_then_read: cover property (
        result_done_i ##[1:4] rd_req && cmd_i.addr == INTEG_SETUP_ADDR
    );

    c_set_clear_clash: cover property (
        result_done_i && data_read_i
    );

    c_turbo_top_rate: cover property (
        setup_o.rate_sps == 11'd2000
    );

    c_temp_mode_on: cover property (
        setup_o.temp_mode && wr_integ
    );

endmodule // adc_setup_regs

// >>> testbench/cmd_master_model.sv
// partner model: serial controller issuing register read and write commands
// assumes the register block answers a read one cycle after the command edge
`timescale 1ns/1ps

module cmd_master_model (
    input  wire logic         core_clk_i,
    input  wire logic [7:0]   rd_data_i,
    input  wire logic         rd_valid_i,
    output adc_cfg_pkg::cmd_s cmd_o
);
    import adc_cfg_pkg::*;

    initial cmd_o = '0;

    // one command, then idle with inverted fields so stale values never match
    task automatic issue(input logic wr, input logic [1:0] addr, input logic [7:0] data);
        @(posedge core_clk_i);
        cmd_o <= '{1'h1, wr, addr, data};
        @(posedge core_clk_i);
        cmd_o <= '{1'h0, ~wr, ~addr, ~data};
    endtask

    // callers keep reserved rate and integrity codes out of the written byte
    task automatic write_reg(input logic [1:0] addr, input logic [7:0] data);
        issue(1'h1, addr, data);
    endtask

    // answer sampled at the edge after the command edge; unknown if none came
    task automatic read_reg(input logic [1:0] addr, output logic [7:0] data);
        issue(1'h0, addr, 8'h00);
        @(posedge core_clk_i);
        data = rd_valid_i ? rd_data_i : 8'hxx;
    endtask
endmodule // cmd_master_model

// >>> testbench/adc_setup_regs_tb_top.sv
// testbench: register commands and conversion events, answers compared
// assumes the partner model issues commands; one clock, async reset
`timescale 1ns/1ps

module adc_setup_regs_tb_top;
    import adc_cfg_pkg::*;

    logic         core_clk_i;
    logic         reset_i;
    cmd_s         cmd;
    logic         power_down_i;
    logic         result_done_i;
    logic         data_read_i;
    logic [7:0]   rd_data;
    logic         rd_valid;
    setup_s       setup;
    logic [7:0]   sample_count;
    logic         power_down_o;
    logic [7:0]   got;
    logic [7:0]   b;
    int           n_mismatch;
    int           comparisons;
    int           cycles;

    adc_setup_regs i_adc_setup_regs (
        .core_clk_i     (core_clk_i),
        .reset_i        (reset_i),
        .cmd_i          (cmd),
        .power_down_i   (power_down_i),
        .result_done_i  (result_done_i),
        .data_read_i    (data_read_i),
        .rd_data_o      (rd_data),
        .rd_valid_o     (rd_valid),
        .setup_o        (setup),
        .sample_count_o (sample_count),
        .power_down_o   (power_down_o)
    );

    cmd_master_model i_cmd_master_model (
        .core_clk_i (core_clk_i),
        .rd_data_i  (rd_data),
        .rd_valid_i (rd_valid),
        .cmd_o      (cmd)
    );

    // 100 ns clock
    initial begin
        core_clk_i = 1'h0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    task automatic check_reg(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic check_field(input logic [10:0] g, input logic [10:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        i_cmd_master_model.write_reg(a, d);
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        i_cmd_master_model.read_reg(a, got);
        check_reg(got, e);
    endtask

    // decoded settings lag the register by one edge; look past it
    task automatic settle();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask

    task automatic conclude();
        $display("counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        reset_i = 1'h1;
        power_down_i = 1'h0;
        result_done_i = 1'h0;
        data_read_i = 1'h0;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'h0;
        rd(CONV_SETUP_ADDR, 8'h00);
        rd(INTEG_SETUP_ADDR, 8'h00);
        check_field(setup.mod_clk_khz, 11'h100);
        check_field(setup.rate_sps, 11'h014);
        $display("test reset done");
        // rate codes zero to six in both speed modes; reserved code seven not written
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 7; c++) begin
                wr(CONV_SETUP_ADDR, {c[2:0], s[0], 4'h0});
                settle();
                check_field(setup.rate_sps, NORMAL_SPS[c] << s);
                check_field(setup.mod_clk_khz, s[0] ? 11'h200 : 11'h100);
                check_field(setup.reserved_code, 1'h0);
                rd(CONV_SETUP_ADDR, {c[2:0], s[0], 4'h0});
            end
        end
        $display("test rates done");
        // reference codes with temperature mode off, conversion bit varied
        for (int r = 0; r < 4; r++) begin
            wr(CONV_SETUP_ADDR, {4'h0, r[1], r[1:0], 1'h0});
            settle();
            check_field(setup.ref_sel, (r == 3) ? 11'h002 : 11'(r));
            check_field(setup.continuous, r[1]);
            check_field(setup.temp_mode, 1'h0);
            check_field(setup.cfg0_bypass, 1'h0);
        end
        // temperature mode overrides the supply reference code
        wr(CONV_SETUP_ADDR, 8'h0F);
        settle();
        check_field(setup.ref_sel, 11'h000);
        check_field(setup.continuous, 1'h1);
        check_field(setup.temp_mode, 1'h1);
        check_field(setup.cfg0_bypass, 1'h1);
        $display("test reference done");
        // second register, ready bit written high each time
        for (int e = 0; e < 8; e++) begin
            b = {1'h1, e[0], 2'(e % 3), e[2], e[2:0]};
            wr(INTEG_SETUP_ADDR, b);
            settle();
            rd(INTEG_SETUP_ADDR, {1'h0, b[6:0]});
            check_field(setup.exc_ua, EXC_UA[e]);
            check_field(setup.integrity, b[5:4]);
            check_field(setup.burnout_en, b[3]);
            check_field(setup.counter_en, b[6]);
        end
        $display("test second register done");
        // three results back to back, then one read-out
        wr(INTEG_SETUP_ADDR, 8'h40);
        @(posedge core_clk_i);
        result_done_i <= 1'h1;
        repeat (3) @(posedge core_clk_i);
        result_done_i <= 1'h0;
        rd(INTEG_SETUP_ADDR, 8'hC0);
        check_field(sample_count, 11'h003);
        data_read_i <= 1'h1;
        @(posedge core_clk_i);
        data_read_i <= 1'h0;
        rd(INTEG_SETUP_ADDR, 8'h40);
        // result and read-out in one cycle: the new result wins
        result_done_i <= 1'h1;
        data_read_i <= 1'h1;
        @(posedge core_clk_i);
        result_done_i <= 1'h0;
        data_read_i <= 1'h0;
        rd(INTEG_SETUP_ADDR, 8'hC0);
        check_field(sample_count, 11'h004);
        wr(INTEG_SETUP_ADDR, 8'h00);
        settle();
        check_field(sample_count, 11'h000);
        $display("test events done");
        // power-down keeps values; unmapped places read zero, take no write
        power_down_i <= 1'h1;
        wr(2'h3, 8'hFF);
        wr(2'h0, 8'hFF);
        rd(CONV_SETUP_ADDR, 8'h0F);
        check_field(power_down_o, 1'h1);
        rd(2'h3, UNMAPPED_READ);
        rd(2'h0, 8'h00);
        $display("test power-down and unmapped done");
        // reset in mid-run brings both registers and the ready flag back to zero
        reset_i <= 1'h1;
        power_down_i <= 1'h0;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'h0;
        rd(CONV_SETUP_ADDR, CONV_SETUP_RESET);
        rd(INTEG_SETUP_ADDR, INTEG_SETUP_RESET);
        check_field(setup.rate_sps, 11'h014);
        check_field(power_down_o, 1'h0);
        $display("test mid-run reset done");
        conclude();
    end
endmodule // adc_setup_regs_tb_top
